//--- core/init_seq_consts.svh
// Offsets, field positions, reset values and counts of the init sequencer
`ifndef INIT_SEQ_CONSTS_SVH
`define INIT_SEQ_CONSTS_SVH
`define OFS_CTRL 8'h00
`define OFS_STATUS 8'h04
`define OFS_CTL0 8'h08
`define OFS_FAULT_ADDR 8'h0c
`define OFS_PT_BASE 8'h10
`define OFS_FEAT_CTL 8'h14
`define OFS_TASK_PRIO 8'h18
`define OFS_FLAGS 8'h1c
`define OFS_EXT_FEAT 8'h20
`define OFS_IP 8'h24
`define OFS_CS_SEL 8'h28
`define OFS_CS_BASE 8'h2c
`define OFS_CS_LIMIT 8'h30
`define OFS_SEG_LIMIT 8'h34
`define OFS_ACC 8'h38
`define OFS_XSTATE 8'h3c
`define CTRL_TEST_EN 0
`define CTRL_MULT_OVR 1
`define CTRL_MULT_LSB 4
`define CTL0_HARD 32'h6000_0010
`define CTL0_WARM 32'h0000_0010
`define CTL0_KEEP 32'h6000_0000
`define CTL0_PE 0
`define FLAGS_INIT 32'h0000_0002
`define IP_INIT 32'h0000_fff0
`define CS_SEL_INIT 32'h0000_f000
`define CS_BASE_INIT 32'hffff_0000
`define LIMIT_INIT 32'h0000_ffff
`define XSTATE_HARD 32'h0000_0001
`define ACC_FAIL 32'h0000_0001
`define SELF_TEST_CYCLES 4096
`endif

//--- core/init_seq_pkg.sv
// Types shared by the init sequencer
package init_seq_pkg;
  typedef enum logic [1:0] {
    ST_HARD = 2'b00,
    ST_TEST = 2'b01,
    ST_WARM = 2'b10,
    ST_RUN = 2'b11
  } init_state_e;
  typedef logic [31:0] word_t;
endpackage : init_seq_pkg

//--- core/processor_reset_init_state.sv
// Processor hard reset / warm restart initial-state sequencer
//
// Strobed register access and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "init_seq_consts.svh"
module processor_reset_init_state #(
  parameter int MULT_W = 4,
  parameter int SELF_TEST_CYCLES = `SELF_TEST_CYCLES
) (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic hard_reset_pin_n_i,
  input wire logic cross_core_interrupt_i,
  input wire logic array_fault_i,
  input wire logic [MULT_W-1:0] clk_mult_strap_i,
  input wire logic [7:0] addr_i,
  input wire init_seq_pkg::word_t wr_data_i,
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  output init_seq_pkg::word_t rd_data_o,
  output logic exec_run_o,
  output logic real_mode_o,
  output logic self_test_busy_o,
  output logic [MULT_W-1:0] core_clk_mult_o
);
  import init_seq_pkg::*;

  localparam int SW = MULT_W + 3;

  // Counter must hold the full self-test length
  if (SELF_TEST_CYCLES < 1 || SELF_TEST_CYCLES > 16777215
      || MULT_W < 1 || MULT_W > 8) begin : g_bad_param
    $error("processor_reset_init_state: bad parameter");
  end

  // Pin inputs, two flops each
  logic [SW-1:0] sync1_r;
  logic [SW-1:0] sync2_r;
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= {clk_mult_strap_i, array_fault_i, cross_core_interrupt_i, hard_reset_pin_n_i};
      sync2_r <= sync1_r;
    end
  end

  logic hard_held;
  logic warm_req;
  logic fault_s;
  logic [MULT_W-1:0] strap_s;
  assign hard_held = ~sync2_r[0];
  assign warm_req = sync2_r[1];
  assign fault_s = sync2_r[2];
  assign strap_s = sync2_r[SW-1:3];

  // State registers
  init_state_e state_r, state_nxt;
  logic [23:0] cnt_r, cnt_nxt;
  logic fault_r, fault_nxt;
  word_t ctrl_r, ctrl_nxt;
  word_t ctl0_r, ctl0_nxt;
  word_t fault_addr_r, fault_addr_nxt;
  word_t pt_base_r, pt_base_nxt;
  word_t feat_ctl_r, feat_ctl_nxt;
  word_t task_prio_r, task_prio_nxt;
  word_t flags_r, flags_nxt;
  word_t ext_feat_r, ext_feat_nxt;
  word_t ip_r, ip_nxt;
  word_t cs_sel_r, cs_sel_nxt;
  word_t cs_base_r, cs_base_nxt;
  word_t cs_limit_r, cs_limit_nxt;
  word_t seg_limit_r, seg_limit_nxt;
  word_t acc_r, acc_nxt;
  word_t xstate_r, xstate_nxt;
  logic [MULT_W-1:0] strap_r, strap_nxt;
  word_t rd_data_nxt;

  logic wr_run;
  assign wr_run = wr_en_i && (state_r == ST_RUN);

  // Sequencer and architectural state; hard pin outranks warm request
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    fault_nxt = fault_r;
    ctrl_nxt = ctrl_r;
    ctl0_nxt = ctl0_r;
    fault_addr_nxt = fault_addr_r;
    pt_base_nxt = pt_base_r;
    feat_ctl_nxt = feat_ctl_r;
    task_prio_nxt = task_prio_r;
    flags_nxt = flags_r;
    ext_feat_nxt = ext_feat_r;
    ip_nxt = ip_r;
    cs_sel_nxt = cs_sel_r;
    cs_base_nxt = cs_base_r;
    cs_limit_nxt = cs_limit_r;
    seg_limit_nxt = seg_limit_r;
    acc_nxt = acc_r;
    xstate_nxt = xstate_r;
    strap_nxt = strap_r;
    if (wr_en_i && addr_i == `OFS_CTRL) begin
      ctrl_nxt = wr_data_i;
    end
    if (hard_held || warm_req) begin
      // Common initial state, real mode
      fault_addr_nxt = '0;
      pt_base_nxt = '0;
      feat_ctl_nxt = '0;
      ext_feat_nxt = '0;
      flags_nxt = `FLAGS_INIT;
      seg_limit_nxt = `LIMIT_INIT;
      ip_nxt = `IP_INIT;
      cs_sel_nxt = `CS_SEL_INIT;
      cs_base_nxt = `CS_BASE_INIT;
      cs_limit_nxt = `LIMIT_INIT;
      acc_nxt = '0;
      cnt_nxt = '0;
      fault_nxt = 1'b0;
    end
    if (hard_held) begin
      state_nxt = ST_HARD;
      ctl0_nxt = `CTL0_HARD;
      task_prio_nxt = '0;
      xstate_nxt = `XSTATE_HARD;
      strap_nxt = strap_s;
    end else if (warm_req) begin
      // Warm path may cut a running self-test short
      state_nxt = ST_WARM;
      ctl0_nxt = (ctl0_r & `CTL0_KEEP) | `CTL0_WARM;
    end else begin
      case (state_r)
        ST_HARD: begin
          if (ctrl_r[`CTRL_TEST_EN]) begin
            state_nxt = ST_TEST;
          end else begin
            state_nxt = ST_RUN;
          end
        end
        ST_TEST: begin
          fault_nxt = fault_r | fault_s;
          cnt_nxt = cnt_r + 24'h1;
          if (cnt_r == 24'(SELF_TEST_CYCLES - 1)) begin
            acc_nxt = (fault_r | fault_s) ? `ACC_FAIL : '0;
            state_nxt = ST_RUN;
          end
        end
        ST_WARM: begin
          state_nxt = ST_RUN;
        end
        ST_RUN: begin
          // Software may change state once running
          if (wr_run) begin
            case (addr_i)
              `OFS_CTL0: ctl0_nxt = wr_data_i;
              `OFS_FAULT_ADDR: fault_addr_nxt = wr_data_i;
              `OFS_PT_BASE: pt_base_nxt = wr_data_i;
              `OFS_FEAT_CTL: feat_ctl_nxt = wr_data_i;
              `OFS_TASK_PRIO: task_prio_nxt = wr_data_i;
              `OFS_FLAGS: flags_nxt = wr_data_i;
              `OFS_EXT_FEAT: ext_feat_nxt = wr_data_i;
              `OFS_IP: ip_nxt = wr_data_i;
              `OFS_ACC: acc_nxt = wr_data_i;
              `OFS_XSTATE: xstate_nxt = wr_data_i;
              default: begin
              end
            endcase
          end
        end
        default: begin
          state_nxt = ST_HARD;
        end
      endcase
    end
  end

  // State flops; power-on equals the hard reset image except ctrl_r and strap_r, which load zero
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_r <= ST_HARD;
      cnt_r <= '0;
      fault_r <= 1'b0;
      ctrl_r <= '0;
      ctl0_r <= `CTL0_HARD;
      fault_addr_r <= '0;
      pt_base_r <= '0;
      feat_ctl_r <= '0;
      task_prio_r <= '0;
      flags_r <= `FLAGS_INIT;
      ext_feat_r <= '0;
      ip_r <= `IP_INIT;
      cs_sel_r <= `CS_SEL_INIT;
      cs_base_r <= `CS_BASE_INIT;
      cs_limit_r <= `LIMIT_INIT;
      seg_limit_r <= `LIMIT_INIT;
      acc_r <= '0;
      xstate_r <= `XSTATE_HARD;
      strap_r <= '0;
      rd_data_o <= '0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      fault_r <= fault_nxt;
      ctrl_r <= ctrl_nxt;
      ctl0_r <= ctl0_nxt;
      fault_addr_r <= fault_addr_nxt;
      pt_base_r <= pt_base_nxt;
      feat_ctl_r <= feat_ctl_nxt;
      task_prio_r <= task_prio_nxt;
      flags_r <= flags_nxt;
      ext_feat_r <= ext_feat_nxt;
      ip_r <= ip_nxt;
      cs_sel_r <= cs_sel_nxt;
      cs_base_r <= cs_base_nxt;
      cs_limit_r <= cs_limit_nxt;
      seg_limit_r <= seg_limit_nxt;
      acc_r <= acc_nxt;
      xstate_r <= xstate_nxt;
      strap_r <= strap_nxt;
      rd_data_o <= rd_data_nxt;
    end
  end

  // Read mux; unmapped words read zero
  always_comb begin
    rd_data_nxt = '0;
    if (rd_en_i) begin
      case (addr_i)
        `OFS_CTRL: rd_data_nxt = ctrl_r;
        `OFS_STATUS: rd_data_nxt = {28'h0, fault_r, exec_run_o, state_r};
        `OFS_CTL0: rd_data_nxt = ctl0_r;
        `OFS_FAULT_ADDR: rd_data_nxt = fault_addr_r;
        `OFS_PT_BASE: rd_data_nxt = pt_base_r;
        `OFS_FEAT_CTL: rd_data_nxt = feat_ctl_r;
        `OFS_TASK_PRIO: rd_data_nxt = task_prio_r;
        `OFS_FLAGS: rd_data_nxt = flags_r;
        `OFS_EXT_FEAT: rd_data_nxt = ext_feat_r;
        `OFS_IP: rd_data_nxt = ip_r;
        `OFS_CS_SEL: rd_data_nxt = cs_sel_r;
        `OFS_CS_BASE: rd_data_nxt = cs_base_r;
        `OFS_CS_LIMIT: rd_data_nxt = cs_limit_r;
        `OFS_SEG_LIMIT: rd_data_nxt = seg_limit_r;
        `OFS_ACC: rd_data_nxt = acc_r;
        `OFS_XSTATE: rd_data_nxt = xstate_r;
        default: rd_data_nxt = '0;
      endcase
    end
  end

  // Status outputs
  assign exec_run_o = (state_r == ST_RUN);
  assign real_mode_o = ~ctl0_r[`CTL0_PE];
  assign self_test_busy_o = (state_r == ST_TEST);
  // Software override wins over the strap caught during hard reset
  assign core_clk_mult_o = ctrl_r[`CTRL_MULT_OVR]
    ? ctrl_r[`CTRL_MULT_LSB +: MULT_W] : strap_r;

  property p_hard_ctl0;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    hard_held |=> ctl0_r == `CTL0_HARD && xstate_r == `XSTATE_HARD;
  endproperty
  a_hard_ctl0: assert property (p_hard_ctl0) else $error("hard image wrong");

  property p_warm_ctl0;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    (!hard_held && warm_req) |=>
      ctl0_r == (($past(ctl0_r) & `CTL0_KEEP) | `CTL0_WARM);
  endproperty
  a_warm_ctl0: assert property (p_warm_ctl0) else $error("warm control wrong");

  property p_held_no_run;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    (hard_held || warm_req) |=> !exec_run_o;
  endproperty
  a_held_no_run: assert property (p_held_no_run) else $error("ran while held");

  property p_start_state;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    $rose(exec_run_o) |-> ip_r == `IP_INIT && cs_sel_r == `CS_SEL_INIT
      && cs_base_r == `CS_BASE_INIT && flags_r == `FLAGS_INIT && real_mode_o;
  endproperty
  a_start_state: assert property (p_start_state) else $error("bad start state");

  property p_warm_keep;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    (state_r == ST_WARM && !hard_held) |=> $stable(xstate_r) && $stable(task_prio_r);
  endproperty
  a_warm_keep: assert property (p_warm_keep) else $error("warm changed kept reg");

  property p_warm_acc;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    (state_r == ST_WARM && state_nxt == ST_RUN) |=> exec_run_o && acc_r == '0;
  endproperty
  a_warm_acc: assert property (p_warm_acc) else $error("accumulator not zero");

  property p_test_fail;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    (state_r == ST_TEST && state_nxt == ST_RUN && (fault_r || fault_s))
      |=> acc_r != '0 && exec_run_o;
  endproperty
  a_test_fail: assert property (p_test_fail) else $error("fault not reported");

  property p_warm_any;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    (warm_req && !hard_held) |=> state_r == ST_WARM [*1] ##1 1'b1;
  endproperty
  a_warm_any: assert property (p_warm_any) else $error("warm not taken");

  property p_hard_prio;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    (hard_held && !$past(hard_held)) |=> task_prio_r == '0 && state_r == ST_HARD;
  endproperty
  a_hard_prio: assert property (p_hard_prio) else $error("hard image incomplete");

  property p_mult;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    !ctrl_r[`CTRL_MULT_OVR] && $past(hard_held) |-> core_clk_mult_o == $past(strap_s);
  endproperty
  a_mult: assert property (p_mult) else $error("strap multiplier wrong");

endmodule : processor_reset_init_state

//--- tb/init_partner.sv
// Model of the board reset logic and a peer core asking for restarts
`timescale 1ns/1ps
module init_partner (
  input wire logic clk_sys_i,
  input wire logic hard_req_i,
  input wire logic warm_req_i,
  input wire logic fault_req_i,
  output logic hard_pin_n_o,
  output logic warm_req_o,
  output logic fault_o
);
  // Pin starts low, since power has just come back
  initial begin
    hard_pin_n_o = 1'b0;
    warm_req_o = 1'b0;
    fault_o = 1'b0;
  end
  // Levels launched on the clock, as board logic would
  always @(posedge clk_sys_i) begin
    hard_pin_n_o <= ~hard_req_i;
    warm_req_o <= warm_req_i;
    fault_o <= fault_req_i;
  end
endmodule : init_partner

//--- tb/tb_top.sv
// Self-checking bench for the init-state sequencer
`timescale 1ns/1ps
module tb_top;
  import init_seq_pkg::*;
  logic clk_sys_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic hard_req = 1'b1;
  logic warm_req = 1'b0;
  logic fault_req = 1'b0;
  logic hard_pin_n, warm_pin, fault_pin, exec_run, real_mode, test_busy;
  logic busy_seen = 1'b0;
  logic rd_pend = 1'b0;
  logic [3:0] strap = 4'h0;
  logic [3:0] mult;
  logic [7:0] addr = 8'h00;
  word_t wdata = '0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  word_t rd_data, w0, tp, xs, v;
  int err_count = 0;
  int compares = 0;
  int seed = 55;
  word_t exp_q[$];
  string name_q[$];
  logic [7:0] tbl_a [14] = '{8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20, 8'h24, 8'h28,
    8'h2c, 8'h30, 8'h34, 8'h38, 8'h3c};
  word_t tbl_v [14] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h2, 32'h0, 32'hfff0, 32'hf000,
    32'hffff_0000, 32'hffff, 32'hffff, 32'h0, 32'h0};

  // Clock at 100 MHz
  initial begin
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  init_partner dut_p (.clk_sys_i(clk_sys_i), .hard_req_i(hard_req), .warm_req_i(warm_req),
    .fault_req_i(fault_req), .hard_pin_n_o(hard_pin_n), .warm_req_o(warm_pin),
    .fault_o(fault_pin));

  // Short self-test keeps the run brief
  processor_reset_init_state #(.MULT_W(4), .SELF_TEST_CYCLES(8)) dut_u (
    .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .hard_reset_pin_n_i(hard_pin_n),
    .cross_core_interrupt_i(warm_pin), .array_fault_i(fault_pin), .clk_mult_strap_i(strap),
    .addr_i(addr), .wr_data_i(wdata), .wr_en_i(wr_en), .rd_en_i(rd_en), .rd_data_o(rd_data),
    .exec_run_o(exec_run), .real_mode_o(real_mode), .self_test_busy_o(test_busy),
    .core_clk_mult_o(mult));

  // Read data lives one cycle only; check it mid-cycle once settled
  always @(posedge clk_sys_i) begin
    rd_pend <= rd_en;
    if (test_busy === 1'b1) busy_seen <= 1'b1;
  end
  always @(negedge clk_sys_i) begin
    if (rd_pend && exp_q.size() > 0) chk_word(name_q.pop_front(), exp_q.pop_front(), rd_data);
  end

  task automatic chk_word(input string nm, input word_t e, input word_t g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_word

  task automatic chk_bit(input string nm, input logic [3:0] e, input logic [3:0] g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_bit

  task automatic wr(input logic [7:0] a, input word_t d);
    @(posedge clk_sys_i);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk_sys_i);
    wr_en <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input word_t e, input string nm);
    @(posedge clk_sys_i);
    addr <= a;
    rd_en <= 1'b1;
    exp_q.push_back(e);
    name_q.push_back(nm);
    @(posedge clk_sys_i);
    rd_en <= 1'b0;
  endtask : rd

  // Bounded wait for the run flag, then compare it
  task automatic wait_run(input logic lv);
    int n;
    n = 0;
    while (exec_run !== lv && n < 300) begin
      @(posedge clk_sys_i);
      n++;
    end
    chk_bit("exec_run", {3'b0, lv}, {3'b0, exec_run});
  endtask : wait_run

  // Reads every mapped state word; kept words passed in
  task automatic check_image(input word_t c0, input word_t pr, input word_t mk, input word_t ac);
    word_t e;
    for (int i = 0; i < 14; i++) begin
      case (tbl_a[i])
        8'h08: e = c0;
        8'h18: e = pr;
        8'h38: e = ac;
        8'h3c: e = mk;
        default: e = tbl_v[i];
      endcase
      rd(tbl_a[i], e, $sformatf("reg_%h", tbl_a[i]));
    end
  endtask : check_image

  // Hard pin pulse with a fresh strap value
  task automatic hard_cycle(input logic fault);
    @(posedge clk_sys_i);
    hard_req <= 1'b1;
    fault_req <= fault;
    strap <= 4'($random(seed));
    wait_run(1'b0);
    repeat (4) @(posedge clk_sys_i);
    hard_req <= 1'b0;
  endtask : hard_cycle

  task automatic test_done;
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : test_done

  // Watchdog well beyond the expected few hundred cycles
  initial begin
    repeat (5000) @(posedge clk_sys_i);
    err_count++;
    test_done();
  end

  initial begin
    repeat (20) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    strap <= 4'($random(seed));
    repeat (4) @(posedge clk_sys_i);
    chk_bit("exec_held", 4'h0, {3'b0, exec_run});
    hard_req <= 1'b0;
    wait_run(1'b1);
    chk_bit("mult_strap", strap, mult);
    chk_bit("real_mode", 4'h1, {3'b0, real_mode});
    check_image(32'h6000_0010, '0, 32'h1, '0);
    rd(8'h04, 32'h0000_0007, "status_run");
    // Dirty the state, then warm restart
    w0 = $random(seed);
    tp = $random(seed);
    xs = $random(seed);
    wr(8'h08, w0);
    wr(8'h18, tp);
    wr(8'h3c, xs);
    wr(8'h1c, $random(seed));
    wr(8'h0c, $random(seed));
    wr(8'h28, $random(seed));
    wr(8'h38, $random(seed));
    chk_bit("real_mode_sw", {3'b0, ~w0[0]}, {3'b0, real_mode});
    rd(8'h18, tp, "prio_rw");
    rd(8'h28, 32'h0000_f000, "cs_sel_ro");
    rd(8'h40, '0, "unmapped");
    warm_req <= 1'b1;
    wait_run(1'b0);
    warm_req <= 1'b0;
    wait_run(1'b1);
    chk_bit("real_mode", 4'h1, {3'b0, real_mode});
    check_image((w0 & 32'h6000_0000) | 32'h10, tp, xs, '0);
    // Software multiplier and self-test, first with a fault
    v = word_t'($random(seed)) & 32'hf0;
    wr(8'h00, v | 32'h3);
    repeat (2) @(posedge clk_sys_i);
    chk_bit("mult_sw", v[7:4], mult);
    hard_cycle(1'b1);
    wait_run(1'b1);
    chk_bit("busy_seen", 4'h1, {3'b0, busy_seen});
    rd(8'h38, 32'h1, "acc_fail");
    rd(8'h04, 32'h0000_000f, "status_fail");
    hard_cycle(1'b0);
    wait_run(1'b1);
    check_image(32'h6000_0010, '0, 32'h1, '0);
    chk_bit("mult_sw", v[7:4], mult);
    repeat (4) @(posedge clk_sys_i);
    test_done();
  end
endmodule : tb_top
